/* File: src/branch_skip_pkg.sv */
// constants for the conditional skip and relative branch unit
// assumes a word-wide ahb-lite register bus and an 8-bit flag vector
package branch_skip_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] PC_OFF      = 8'h04;
  localparam logic [7:0] FLAGS_OFF   = 8'h08;
  localparam logic [7:0] INSN_OFF    = 8'h0C;
  localparam logic [7:0] OPERAND_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF  = 8'h14;

  // instruction register fields
  localparam int OP_LSB      = 0;
  localparam int BIT_LSB     = 4;
  localparam int DISP_LSB    = 8;
  localparam int TWO_WORD_POS = 16;

  // status register fields
  localparam int ST_BUSY_POS  = 0;
  localparam int ST_TAKEN_POS = 1;
  localparam int ST_CLK_LSB   = 2;
  localparam int ST_ERR_POS   = 8;

  // flag positions inside the status flag vector
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // reset values
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  FLAGS_RST = 8'h00;

  // clocks per outcome
  localparam logic [1:0] CLK_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CLK_BRANCH    = 2'h2;
  localparam logic [1:0] CLK_SKIP_ONE  = 2'h2;
  localparam logic [1:0] CLK_SKIP_TWO  = 2'h3;

  typedef enum logic [3:0] {
    OP_SKIP_REG_BIT_SET     = 4'b0000,
    OP_SKIP_IO_BIT_CLEAR    = 4'b0001,
    OP_SKIP_IO_BIT_SET      = 4'b0010,
    OP_BRANCH_FLAG_SET      = 4'b0011,
    OP_BRANCH_FLAG_CLEAR    = 4'b0100,
    OP_BRANCH_CARRY_SET     = 4'b0101,
    OP_BRANCH_CARRY_CLEAR   = 4'b0110,
    OP_BRANCH_SAME_HIGHER   = 4'b0111,
    OP_BRANCH_LOWER         = 4'b1000,
    OP_BRANCH_GE_SIGNED     = 4'b1001,
    OP_BRANCH_LT_SIGNED     = 4'b1010,
    OP_BRANCH_HCARRY_SET    = 4'b1011,
    OP_BRANCH_HCARRY_CLEAR  = 4'b1100
  } opcode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } exec_state_t;

endpackage : branch_skip_pkg

/* File: src/skip_cond_eval.sv */
// condition test for skip and branch instructions
// assumes operand and flags are stable while the opcode is presented
`timescale 1ns/100ps
`default_nettype none

module skip_cond_eval
  (
    input  wire logic [3:0] op,
    input  wire logic [2:0] bit_sel,
    input  wire logic [7:0] operand,
    input  wire logic [7:0] flags,
    output logic            cond_true,
    output logic            is_skip,
    output logic            bad_op
  );

  function automatic logic pick(input logic [7:0] v, input logic [2:0] b);
    pick = v[b];
  endfunction : pick

  logic c_f;
  logic h_f;
  logic s_f;

  always_comb
  begin
    c_f = flags[branch_skip_pkg::FLAG_C];
    h_f = flags[branch_skip_pkg::FLAG_H];
    s_f = flags[branch_skip_pkg::FLAG_N] ^ flags[branch_skip_pkg::FLAG_V];
    cond_true = 1'b0;
    is_skip   = 1'b0;
    bad_op    = 1'b0;
    case (op)
      branch_skip_pkg::OP_SKIP_REG_BIT_SET:
      begin
        cond_true = pick(operand, bit_sel);
        is_skip   = 1'b1;
      end
      branch_skip_pkg::OP_SKIP_IO_BIT_CLEAR:
      begin
        cond_true = ~pick(operand, bit_sel);
        is_skip   = 1'b1;
      end
      branch_skip_pkg::OP_SKIP_IO_BIT_SET:
      begin
        cond_true = pick(operand, bit_sel);
        is_skip   = 1'b1;
      end
      branch_skip_pkg::OP_BRANCH_FLAG_SET:    cond_true = pick(flags, bit_sel);
      branch_skip_pkg::OP_BRANCH_FLAG_CLEAR:  cond_true = ~pick(flags, bit_sel);
      branch_skip_pkg::OP_BRANCH_CARRY_SET:   cond_true = c_f;
      branch_skip_pkg::OP_BRANCH_CARRY_CLEAR: cond_true = ~c_f;
      branch_skip_pkg::OP_BRANCH_SAME_HIGHER: cond_true = ~c_f;
      branch_skip_pkg::OP_BRANCH_LOWER:       cond_true = c_f;
      branch_skip_pkg::OP_BRANCH_GE_SIGNED:   cond_true = ~s_f;
      branch_skip_pkg::OP_BRANCH_LT_SIGNED:   cond_true = s_f;
      branch_skip_pkg::OP_BRANCH_HCARRY_SET:  cond_true = h_f;
      branch_skip_pkg::OP_BRANCH_HCARRY_CLEAR: cond_true = ~h_f;
      // unknown codes fall through in sequence
      default:                                bad_op = 1'b1;
    endcase
  end

endmodule : skip_cond_eval

`default_nettype wire

/* File: src/branch_skip_unit.sv */
// conditional skip and relative branch unit with ahb-lite registers
// assumes a single ahb-lite master, word transfers only, one clock
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - A set register bit skips ahead two or three words.
// - io-bit-clear skips ahead when bit b of io register P is zero.
// - io-bit-set skips ahead when bit b of io register P is one.
// - Flag-set jumps to PC plus k plus one on bit s one, flags kept.
// - Flag-clear jumps to PC plus k plus one when bit s is zero.
// - Carry-set jumps on carry one, carry-clear on carry zero.
// - Same-or-higher jumps on carry zero, lower on carry one.
// - Signed greater-or-equal jumps when N xor V is zero.
// - Signed less-than jumps when N xor V is one.
// - Half-carry-set jumps on H one, half-carry-clear on H zero.
module branch_skip_unit
  #(
    parameter int PC_W   = 16,
    parameter int DISP_W = 7
  )
  (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [PC_W-1:0]  pc_out,
    output logic             busy
  );

  // bus state
  logic            wr_pend_ff;
  logic            nxt_wr_pend;
  logic [7:0]      wr_addr_ff;
  logic [7:0]      nxt_wr_addr;
  logic [31:0]     rdata_ff;
  logic [31:0]     nxt_rdata;
  logic            addr_ok;

  // software registers
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [7:0]      flags_ff;
  logic [7:0]      nxt_flags;
  logic [16:0]     insn_ff;
  logic [16:0]     nxt_insn;
  logic [7:0]      operand_ff;
  logic [7:0]      nxt_operand;

  // execution state
  branch_skip_pkg::exec_state_t state_ff;
  branch_skip_pkg::exec_state_t nxt_state;
  logic [1:0]      remain_ff;
  logic [1:0]      nxt_remain;
  logic [PC_W-1:0] target_ff;
  logic [PC_W-1:0] nxt_target;
  logic            taken_ff;
  logic            nxt_taken;
  logic [1:0]      clocks_ff;
  logic [1:0]      nxt_clocks;
  logic            err_ff;
  logic            nxt_err;

  // decode of the stored instruction
  logic [3:0]        op;
  logic [2:0]        bit_sel;
  logic [DISP_W-1:0] disp;
  logic              two_word;
  logic              cond_true;
  logic              is_skip;
  logic              bad_op;
  logic              start;
  logic              wr_ctrl;
  logic [PC_W-1:0]   disp_ext;
  logic [PC_W-1:0]   seq_pc;
  logic [PC_W-1:0]   calc_target;
  logic [1:0]        calc_clocks;
  logic              calc_taken;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign op       = insn_ff[branch_skip_pkg::OP_LSB +: 4];
  assign bit_sel  = insn_ff[branch_skip_pkg::BIT_LSB +: 3];
  assign disp     = insn_ff[branch_skip_pkg::DISP_LSB +: DISP_W];
  assign two_word = insn_ff[branch_skip_pkg::TWO_WORD_POS];

  skip_cond_eval u_cond
    (
      .op        (op),
      .bit_sel   (bit_sel),
      .operand   (operand_ff),
      .flags     (flags_ff),
      .cond_true (cond_true),
      .is_skip   (is_skip),
      .bad_op    (bad_op)
    );

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign pc_out    = pc_ff;
  assign busy      = (state_ff == branch_skip_pkg::ST_EXEC);

  always_comb
  begin
    addr_ok     = hsel & htrans[1] & hready;
    nxt_wr_pend = addr_ok & hwrite;
    nxt_wr_addr = addr_ok ? haddr[7:0] : wr_addr_ff;
    nxt_rdata   = rdata_ff;
    if (addr_ok & ~hwrite)
    begin
      nxt_rdata = 32'h00000000;
      if (hit(haddr[7:0], branch_skip_pkg::PC_OFF))
        nxt_rdata[PC_W-1:0] = pc_ff;
      else if (hit(haddr[7:0], branch_skip_pkg::FLAGS_OFF))
        nxt_rdata[7:0] = flags_ff;
      else if (hit(haddr[7:0], branch_skip_pkg::INSN_OFF))
        nxt_rdata[16:0] = insn_ff;
      else if (hit(haddr[7:0], branch_skip_pkg::OPERAND_OFF))
        nxt_rdata[7:0] = operand_ff;
      else if (hit(haddr[7:0], branch_skip_pkg::STATUS_OFF))
      begin
        nxt_rdata[branch_skip_pkg::ST_BUSY_POS]     = busy;
        nxt_rdata[branch_skip_pkg::ST_TAKEN_POS]    = taken_ff;
        nxt_rdata[branch_skip_pkg::ST_CLK_LSB +: 2] = clocks_ff;
        nxt_rdata[branch_skip_pkg::ST_ERR_POS]      = err_ff;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff   <= nxt_rdata;
    end
  end

  // outcome of the stored instruction
  always_comb
  begin
    disp_ext    = PC_W'($signed(disp));
    seq_pc      = pc_ff + PC_W'(1);
    calc_target = seq_pc;
    calc_clocks = branch_skip_pkg::CLK_NOT_TAKEN;
    calc_taken  = 1'b0;
    if (!bad_op && cond_true)
    begin
      calc_taken = 1'b1;
      if (is_skip)
      begin
        calc_target = two_word ? pc_ff + PC_W'(3) : pc_ff + PC_W'(2);
        calc_clocks = two_word ? branch_skip_pkg::CLK_SKIP_TWO
                               : branch_skip_pkg::CLK_SKIP_ONE;
      end
      else
      begin
        calc_target = seq_pc + disp_ext;
        calc_clocks = branch_skip_pkg::CLK_BRANCH;
      end
    end
  end

  always_comb
  begin
    wr_ctrl = wr_pend_ff & hit(wr_addr_ff, branch_skip_pkg::CTRL_OFF);
    start   = wr_ctrl & hwdata[0] & (state_ff == branch_skip_pkg::ST_IDLE);
  end

  // registers are frozen while an instruction runs
  always_comb
  begin
    nxt_pc      = pc_ff;
    nxt_flags   = flags_ff;
    nxt_insn    = insn_ff;
    nxt_operand = operand_ff;
    if (wr_pend_ff && state_ff == branch_skip_pkg::ST_IDLE)
    begin
      if (hit(wr_addr_ff, branch_skip_pkg::PC_OFF))
        nxt_pc = hwdata[PC_W-1:0];
      if (hit(wr_addr_ff, branch_skip_pkg::FLAGS_OFF))
        nxt_flags = hwdata[7:0];
      if (hit(wr_addr_ff, branch_skip_pkg::INSN_OFF))
        nxt_insn = hwdata[16:0];
      if (hit(wr_addr_ff, branch_skip_pkg::OPERAND_OFF))
        nxt_operand = hwdata[7:0];
    end
    if (state_ff == branch_skip_pkg::ST_EXEC && remain_ff == 2'h0)
      nxt_pc = target_ff;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_ff      <= PC_W'(branch_skip_pkg::PC_RST);
      flags_ff   <= branch_skip_pkg::FLAGS_RST;
      insn_ff    <= 17'h00000;
      operand_ff <= 8'h00;
    end
    else
    begin
      pc_ff      <= nxt_pc;
      flags_ff   <= nxt_flags;
      insn_ff    <= nxt_insn;
      operand_ff <= nxt_operand;
    end
  end

  // execution sequencer
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_remain = remain_ff;
    nxt_target = target_ff;
    nxt_taken  = taken_ff;
    nxt_clocks = clocks_ff;
    nxt_err    = err_ff;
    case (state_ff)
      branch_skip_pkg::ST_IDLE:
      begin
        if (start)
        begin
          nxt_state  = branch_skip_pkg::ST_EXEC;
          nxt_remain = calc_clocks - 2'h1;
          nxt_target = calc_target;
          nxt_taken  = calc_taken;
          nxt_clocks = calc_clocks;
          nxt_err    = bad_op;
        end
      end
      branch_skip_pkg::ST_EXEC:
      begin
        if (remain_ff == 2'h0)
          nxt_state = branch_skip_pkg::ST_IDLE;
        else
          nxt_remain = remain_ff - 2'h1;
      end
      default:
        nxt_state = branch_skip_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff  <= branch_skip_pkg::ST_IDLE;
      remain_ff <= 2'h0;
      target_ff <= PC_W'(branch_skip_pkg::PC_RST);
      taken_ff  <= 1'b0;
      clocks_ff <= 2'h0;
      err_ff    <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      remain_ff <= nxt_remain;
      target_ff <= nxt_target;
      taken_ff  <= nxt_taken;
      clocks_ff <= nxt_clocks;
      err_ff    <= nxt_err;
    end
  end

endmodule : branch_skip_unit

`default_nettype wire

/* File: sim/branch_skip_unit_checker.sv */
// assertions on the ports of the branch and skip unit
// assumes binding to branch_skip_unit, one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module branch_skip_unit_checker
  #(
    parameter int PC_W = 16
  )
  (
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hsel,
    input wire logic [31:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic [2:0]      hsize,
    input wire logic [31:0]     hwdata,
    input wire logic            hready,
    input wire logic [31:0]     hrdata,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic            busy
  );
  logic take, nxt_ctrl, nxt_pcw, zero_rd, ctrl_ff, pcw_ff;
  always_comb
  begin
    take     = hsel & htrans[1] & hready;
    nxt_ctrl = take & hwrite & (haddr[7:0] == branch_skip_pkg::CTRL_OFF);
    nxt_pcw  = take & hwrite & (haddr[7:0] == branch_skip_pkg::PC_OFF);
    // ctrl reads back zero, so does unmapped space
    zero_rd  = take & ~hwrite & (haddr[7:0] == 8'h00 | haddr[7:0] > 8'h14);
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= 1'b0;
      pcw_ff  <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      pcw_ff  <= nxt_pcw;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence one_clk_s;
    $rose(busy) ##1 !busy;
  endsequence
  sequence three_clk_s;
    $rose(busy) ##1 busy [*2] ##1 !busy;
  endsequence
  a_start_busy: assert property (ctrl_ff && hwdata[0] && !busy |=> busy)
    else $error("start did not raise busy");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("execution longer than three clocks");
  a_pc_hold: assert property (busy ##1 busy |-> $stable(pc_out))
    else $error("pc moved in mid execution");
  a_one_clock: assert property (one_clk_s |->
    pc_out == PC_W'($past(pc_out) + 1)) else $error("one clock not pc+1");
  a_skip_two: assert property (three_clk_s |->
    pc_out == PC_W'($past(pc_out) + 3)) else $error("three clocks not pc+3");
  a_pc_write: assert property (pcw_ff && !busy |=>
    pc_out == $past(hwdata[PC_W-1:0])) else $error("pc write lost");
  a_zero_read: assert property (zero_rd |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_okay_resp: assert property (hresp == 1'b0) else $error("resp not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("wait state seen");
endmodule : branch_skip_unit_checker
bind branch_skip_unit branch_skip_unit_checker #(.PC_W(PC_W)) i_chk
  (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .pc_out(pc_out), .busy(busy));
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the branch and skip unit
// assumes the unit is the only ahb-lite slave and the bench the master
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] pc_out;
  int          n_mismatch, checks_done;
  branch_skip_unit i_branch_skip_unit
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pc_out(pc_out), .busy(busy)
  );
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // entered just after a rising edge; read data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  // returns taken, clocks and next pc
  function automatic logic [18:0] expect_exec(input logic [3:0] op,
    input logic [2:0] b, input logic [6:0] k, input logic two,
    input logic [7:0] v, fl, input logic [15:0] pc);
    logic c;
    c = 1'b0;
    case (op)
      4'h0, 4'h2: c = v[b];
      4'h1: c = ~v[b];
      4'h3: c = fl[b];
      4'h4: c = ~fl[b];
      4'h5, 4'h8: c = fl[0];
      4'h6, 4'h7: c = ~fl[0];
      4'h9: c = ~(fl[2] ^ fl[3]);
      4'hA: c = fl[2] ^ fl[3];
      4'hB: c = fl[5];
      4'hC: c = ~fl[5];
      default: c = 1'b0;
    endcase
    if (!c)
      return {1'b0, 2'h1, pc + 16'h0001};
    if (op < 4'h3)
      return {1'b1, two ? 2'h3 : 2'h2, pc + (two ? 16'h0003 : 16'h0002)};
    return {1'b1, 2'h2, pc + 16'h0001 + {{9{k[6]}}, k}};
  endfunction : expect_exec
  task automatic run(input logic [3:0] op, input logic [15:0] pc,
                     input logic [6:0] k);
    logic [7:0]  v, fl;
    logic [2:0]  b;
    logic        two;
    logic [18:0] e;
    int          n;
    v = 8'($urandom);
    fl = 8'($urandom);
    b = 3'($urandom);
    two = 1'($urandom);
    e = expect_exec(op, b, k, two, v, fl, pc);
    xfer(1'b1, branch_skip_pkg::PC_OFF, {16'h0, pc}, q);
    xfer(1'b1, branch_skip_pkg::FLAGS_OFF, {24'h0, fl}, q);
    xfer(1'b1, branch_skip_pkg::INSN_OFF,
         {15'h0, two, 1'b0, k, 1'b0, b, op}, q);
    xfer(1'b1, branch_skip_pkg::OPERAND_OFF, {24'h0, v}, q);
    xfer(1'b1, branch_skip_pkg::CTRL_OFF, 32'h1, q);
    n = 0;
    // pc write while busy must be dropped
    if (e[17:16] == 2'h3)
    begin
      xfer(1'b1, branch_skip_pkg::PC_OFF, 32'h0000_5A5A, q);
      n = 2;
    end
    do
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    while (busy === 1'b1 && n < 8);
    chk("clocks", {30'h0, e[17:16]}, 32'(n));
    // back onto an edge so the next request starts with it
    @(posedge hclk);
    xfer(1'b0, branch_skip_pkg::PC_OFF, 32'h0, q);
    chk("pc", {16'h0, e[15:0]}, q);
    chk("pc_out", {16'h0, e[15:0]}, {16'h0, pc_out});
    xfer(1'b0, branch_skip_pkg::FLAGS_OFF, 32'h0, q);
    chk("flags", {24'h0, fl}, q);
    xfer(1'b0, branch_skip_pkg::STATUS_OFF, 32'h0, q);
    chk("status", {23'h0, op > 4'hC, 4'h0, e[17:16], e[18], 1'b0}, q);
  endtask : run
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(69762));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, branch_skip_pkg::PC_OFF, 32'h0, q);
    chk("pc reset", 32'h0, q);
    xfer(1'b0, branch_skip_pkg::STATUS_OFF, 32'h0, q);
    chk("status reset", 32'h0, q);
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF, q);
    xfer(1'b0, 8'h1C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    xfer(1'b0, branch_skip_pkg::CTRL_OFF, 32'h0, q);
    chk("ctrl read", 32'h0, q);
    // every opcode; wrap and extreme offsets first
    for (int op = 0; op < 16; op++)
      for (int j = 0; j < 4; j++)
        run(4'(op), j == 0 ? 16'h0000 : (j == 1 ? 16'hFFFF : 16'($urandom)),
            j == 0 ? 7'h40 : (j == 1 ? 7'h3F : 7'($urandom)));
    // reset after the last run must bring the pc back to its reset value
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, branch_skip_pkg::PC_OFF, 32'h0, q);
    chk("pc after reset", 32'(branch_skip_pkg::PC_RST), q);
    chk("pc_out after reset", 32'(branch_skip_pkg::PC_RST), {16'h0, pc_out});
    stop_test;
  end
endmodule : tb
`default_nettype wire
